/* verilog/pmceid_pkg.sv */
// Package for the performance monitor common event identification bank.
// Assumes a single clock domain; imported whole by every design file.
package pmceid_pkg;

    // Register offsets on the external debug interface.
    localparam logic [11:0] PMCEID_OFF_LOW = 12'hE20;
    localparam logic [11:0] PMCEID_OFF_HIGH = 12'hE24;

    // Event numbers, one per bit position; all are in the low register except 8'h20, bit 0 of the high register.
    localparam int PMCEID_EV_SW_INCR = 8'h00;
    localparam int PMCEID_EV_LOAD = 8'h06;
    localparam int PMCEID_EV_STORE = 8'h07;
    localparam int PMCEID_EV_MISALIGNED = 8'h0F;
    localparam int PMCEID_EV_BRANCH_MISPREDICT = 8'h10;
    localparam int PMCEID_EV_CPU_CYCLE = 8'h11;
    localparam int PMCEID_EV_BRANCH_PRED = 8'h12;
    localparam int PMCEID_EV_L2_WRITEBACK = 8'h18;
    localparam int PMCEID_EV_MEM_ERROR = 8'h1A;
    localparam int PMCEID_EV_SPECULATIVE = 8'h1B;
    localparam int PMCEID_EV_TRANSLATION_BASE = 8'h1C;
    localparam int PMCEID_EV_BUS_CYCLE = 8'h1D;
    localparam int PMCEID_EV_CHAIN = 8'h1E;
    localparam int PMCEID_EV_L1_ALLOCATE = 8'h1F;
    localparam int PMCEID_EV_L2_ALLOCATE = 8'h20;

    // Constant contents of the two registers.
    localparam logic [31:0] PMCEID_LOW_VALUE = 32'h7BFF_7F3F;
    localparam logic [31:0] PMCEID_HIGH_VALUE = 32'h0000_0000;

    // Privilege level of a system register access.
    typedef enum logic [1:0] {
        PMCEID_EL_USER = 2'h0,
        PMCEID_EL_KERNEL = 2'h1,
        PMCEID_EL_HYP = 2'h2,
        PMCEID_EL_MONITOR = 2'h3
    } pmceid_el_t;

    // One read or write request from a register path.
    typedef struct packed {
        logic valid;
        logic write;
        logic high_sel;
        pmceid_el_t level;
        logic [31:0] wdata;
    } pmceid_req_t;

    // Answer to a request.
    typedef struct packed {
        logic valid;
        logic error;
        logic [31:0] rdata;
    } pmceid_rsp_t;

    // Debug interface request.
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } pmceid_dbg_req_t;

    // Registered state of the bank.
    typedef struct packed {
        pmceid_rsp_t sys_rsp;
        pmceid_rsp_t dbg_rsp;
    } pmceid_state_t;

endpackage : pmceid_pkg

/* verilog/pmceid_rom.sv */
// Constant value store for the identification registers.
// Assumes callers select the register; holds no state.
`timescale 1ns/1ps
module pmceid_rom
    import pmceid_pkg::*;
(
    // Selection
    input wire logic high_sel,
    // Contents
    output logic [31:0] value
);

    logic [31:0] low_bits;

    // Each bit is set exactly when the event of that number is implemented.
    for (genvar i = 0; i < 32; i++) begin : g_bit
        assign low_bits[i] = PMCEID_LOW_VALUE[i];
    end

    assign value = high_sel ? PMCEID_HIGH_VALUE : low_bits;

endmodule : pmceid_rom

/* verilog/pmceid_bank.sv */
// Top of the common event identification register bank.
// Assumes requests are synchronous to sys_clk and one-cycle pulses.
`timescale 1ns/1ps
module pmceid_bank
    import pmceid_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Access control
    input wire logic user_access_enable_bit,
    // System register paths, 64-bit state and 32-bit coprocessor view
    input wire pmceid_req_t sys_req,
    output pmceid_rsp_t sys_rsp,
    // External debug interface
    input wire pmceid_dbg_req_t dbg_req,
    output pmceid_rsp_t dbg_rsp
);

    pmceid_state_t state_q;
    pmceid_state_t state_d;
    logic [31:0] sys_value;
    logic [31:0] dbg_value;
    logic dbg_hit;
    logic dbg_high;
    logic sys_allowed;
    logic sys_read;
    logic sys_write;
    logic sys_deny;
    logic dbg_read;
    logic dbg_write;
    logic dbg_unmapped;
    logic [31:0] low_bit_ok;
    logic table_ok;

    // Events that the low register reports as absent.
    localparam logic [31:0] PMCEID_ABSENT_MASK =
        (32'h0000_0001 << PMCEID_EV_L1_ALLOCATE) |
        (32'h0000_0001 << PMCEID_EV_MEM_ERROR) |
        (32'h0000_0001 << PMCEID_EV_MISALIGNED) |
        (32'h0000_0001 << PMCEID_EV_STORE) |
        (32'h0000_0001 << PMCEID_EV_LOAD);

    // Cache, TLB, write-back, memory, bus and cycle events.
    localparam logic [31:0] PMCEID_GROUP_MEM_MASK = 32'h23FA_003E;

    // Software, retirement, exception, branch and speculation events.
    localparam logic [31:0] PMCEID_GROUP_INSN_MASK = 32'h1805_7F01;

    // The chaining event, counted only by odd counters.
    localparam logic [31:0] PMCEID_CHAIN_MASK =
        32'h0000_0001 << PMCEID_EV_CHAIN;

    // Compile-time checks of the constant against the event table.
    localparam logic PMCEID_TABLE_OK =
        !PMCEID_LOW_VALUE[PMCEID_EV_L1_ALLOCATE] &&
        !PMCEID_LOW_VALUE[PMCEID_EV_MEM_ERROR] &&
        !PMCEID_LOW_VALUE[PMCEID_EV_MISALIGNED] &&
        !PMCEID_LOW_VALUE[PMCEID_EV_STORE] &&
        !PMCEID_LOW_VALUE[PMCEID_EV_LOAD] &&
        PMCEID_LOW_VALUE[PMCEID_EV_CHAIN] &&
        PMCEID_LOW_VALUE[PMCEID_EV_L2_WRITEBACK] &&
        PMCEID_LOW_VALUE[PMCEID_EV_CPU_CYCLE] &&
        PMCEID_LOW_VALUE[PMCEID_EV_BUS_CYCLE] &&
        PMCEID_LOW_VALUE[PMCEID_EV_SW_INCR] &&
        PMCEID_LOW_VALUE[PMCEID_EV_BRANCH_MISPREDICT] &&
        PMCEID_LOW_VALUE[PMCEID_EV_BRANCH_PRED] &&
        PMCEID_LOW_VALUE[PMCEID_EV_SPECULATIVE] &&
        PMCEID_LOW_VALUE[PMCEID_EV_TRANSLATION_BASE] &&
        !PMCEID_HIGH_VALUE[PMCEID_EV_L2_ALLOCATE - 32] &&
        (PMCEID_HIGH_VALUE[31:1] == 31'h0000_0000);

    // Each bit must be claimed by a present group or by the absent mask, not both, and agree with it.
    // A stale constant then reads as zero instead of a false claim.
    for (genvar b = 0; b < 32; b++) begin : g_audit
        localparam logic PRESENT = PMCEID_GROUP_MEM_MASK[b] ||
            PMCEID_GROUP_INSN_MASK[b] || PMCEID_CHAIN_MASK[b];
        localparam logic ABSENT = PMCEID_ABSENT_MASK[b];
        assign low_bit_ok[b] = (PRESENT != ABSENT) &&
            (PMCEID_LOW_VALUE[b] == PRESENT);
    end

    assign table_ok = PMCEID_TABLE_OK && (&low_bit_ok);

    // Each path has its own store built from the same constants, so the views cannot differ.
    pmceid_rom u_sys_rom (
        .high_sel(sys_req.high_sel),
        .value(sys_value)
    );

    pmceid_rom u_dbg_rom (
        .high_sel(dbg_high),
        .value(dbg_value)
    );

    assign dbg_high = (dbg_req.addr == PMCEID_OFF_HIGH);
    assign dbg_hit = dbg_high || (dbg_req.addr == PMCEID_OFF_LOW);
    assign sys_allowed = (sys_req.level != PMCEID_EL_USER) ||
                         user_access_enable_bit;

    // Request decode on the system register path.
    assign sys_read = sys_req.valid && !sys_req.write;
    assign sys_write = sys_req.valid && sys_req.write;
    assign sys_deny = sys_read && !sys_allowed;

    // Request decode on the debug path.
    assign dbg_read = dbg_req.valid && !dbg_req.write && dbg_hit;
    assign dbg_write = dbg_req.valid && dbg_req.write && dbg_hit;
    assign dbg_unmapped = dbg_req.valid && !dbg_hit;

    always_comb begin
        state_d = '0;
        // System register path.
        state_d.sys_rsp.valid = sys_req.valid;
        // Writes are refused and touch no state.
        if (sys_write) begin
            state_d.sys_rsp.error = 1'b1;
        end
        // User-level reads without the enable are refused.
        if (sys_deny) begin
            state_d.sys_rsp.error = 1'b1;
        end
        if (sys_read && sys_allowed && table_ok) begin
            state_d.sys_rsp.rdata = sys_value;
        end
        // Debug path.
        state_d.dbg_rsp.valid = dbg_req.valid;
        // Unmapped addresses answer with an error.
        if (dbg_unmapped) begin
            state_d.dbg_rsp.error = 1'b1;
        end
        // Mapped writes answer without error and change nothing.
        if (dbg_write) begin
            state_d.dbg_rsp.rdata = 32'h0000_0000;
        end else if (dbg_read && table_ok) begin
            state_d.dbg_rsp.rdata = dbg_value;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sys_rsp = state_q.sys_rsp;
    assign dbg_rsp = state_q.dbg_rsp;

endmodule : pmceid_bank

/* sim/pmceid_bank_props.sv */
// Port checker for the identification bank.
// Bound to pmceid_bank from the testbench top file.
`timescale 1ns/1ps
module pmceid_bank_props
    import pmceid_pkg::*;
(
    // Watched ports
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic user_access_enable_bit,
    input wire pmceid_req_t sys_req,
    input wire pmceid_rsp_t sys_rsp,
    input wire pmceid_dbg_req_t dbg_req,
    input wire pmceid_rsp_t dbg_rsp
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire rd = sys_req.valid && !sys_req.write;
    wire ok = rd &&
        (sys_req.level != PMCEID_EL_USER || user_access_enable_bit);
    wire dr = dbg_req.valid && !dbg_req.write;
    wire lo_a = dbg_req.addr == 12'hE20;
    wire hi_a = dbg_req.addr == 12'hE24;
    answer_a: assert property (sys_req.valid |=> sys_rsp.valid)
        else $error("no answer");
    low_val_a: assert property (ok && !sys_req.high_sel |=>
        !sys_rsp.error && sys_rsp.rdata == 32'h7BFF7F3F) else $error("low");
    high_val_a: assert property (ok && sys_req.high_sel |=>
        !sys_rsp.error && sys_rsp.rdata == 32'h0) else $error("high");
    user_lock_a: assert property (rd && !ok |=> sys_rsp.error)
        else $error("user read let through");
    write_err_a: assert property (sys_req.valid && sys_req.write |=>
        sys_rsp.error && sys_rsp.rdata == 32'h0) else $error("write");
    dbg_low_a: assert property (dr && lo_a |=>
        dbg_rsp.rdata == 32'h7BFF7F3F) else $error("debug low");
    dbg_high_a: assert property (dr && hi_a |=>
        dbg_rsp.valid && dbg_rsp.rdata == 32'h0) else $error("debug high");
    dbg_unmap_a: assert property (dbg_req.valid && !lo_a && !hi_a |=>
        dbg_rsp.error) else $error("unmapped");
    cover property (ok && !sys_req.high_sel);
    cover property (dr && hi_a);
    cover property (sys_req.valid && sys_req.write);
endmodule : pmceid_bank_props

/* sim/pmceid_dbg_host.sv */
// Debug host model driving the external debug request.
// Fed by the testbench shortly after each clock edge.
`timescale 1ns/1ps
module pmceid_dbg_host
    import pmceid_pkg::*;
(
    // Request from the bench
    input wire logic go,
    input wire logic wr,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    // Debug interface
    output pmceid_dbg_req_t dbg_req
);
    // An idle address floats, so show its inverse rather than a hold.
    assign dbg_req = '{go, wr, go ? addr : ~addr, wdata};
endmodule : pmceid_dbg_host

/* sim/pmceid_bank_tb.sv */
// Self-checking bench for the identification bank.
// Drives both request paths and checks every answer.
`timescale 1ns/1ps
module pmceid_bank_tb
    import pmceid_pkg::*;
;
    logic sys_clk = 0;
    logic resetn = 0;
    logic user_access_enable_bit = 0;
    logic go = 0;
    logic wr = 0;
    logic [11:0] addr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] lo;
    pmceid_req_t sys_req = '0;
    pmceid_rsp_t sys_rsp;
    pmceid_rsp_t dbg_rsp;
    pmceid_dbg_req_t dbg_req;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    pmceid_bank i_dut(.sys_clk(sys_clk), .resetn(resetn),
        .user_access_enable_bit(user_access_enable_bit), .sys_req(sys_req),
        .sys_rsp(sys_rsp), .dbg_req(dbg_req), .dbg_rsp(dbg_rsp));
    pmceid_dbg_host i_host(.go(go), .wr(wr), .addr(addr), .wdata(wdat),
        .dbg_req(dbg_req));
    task final_report;
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task chk(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task sys_op(input logic hi, input logic [1:0] lv, input logic w);
        logic e;
        @(posedge sys_clk) #1;
        sys_req = '{1'b1, w, hi, pmceid_el_t'(lv), $urandom};
        e = w | (lv == 2'h0 & !user_access_enable_bit);
        @(posedge sys_clk) #1;
        sys_req.valid = 1'b0;
        chk({sys_rsp.valid, sys_rsp.error, sys_rsp.rdata},
            {1'b1, e, (e | hi) ? 32'h0 : lo});
    endtask : sys_op
    task dbg_op(input logic [11:0] a, input logic w);
        logic m;
        @(posedge sys_clk) #1;
        {go, wr, addr, wdat} = {1'b1, w, a, $urandom};
        m = a == 12'hE20 || a == 12'hE24;
        @(posedge sys_clk) #1;
        go = 0;
        chk({dbg_rsp.valid, dbg_rsp.error, dbg_rsp.rdata},
            {1'b1, !m, (m && !w && a == 12'hE20) ? lo : 32'h0});
    endtask : dbg_op
    initial begin
        lo = ~(32'h1 << 31 | 32'h1 << 26 | 32'h1 << 15 | 32'hC0);
        void'($urandom(32'hA7D7));
        repeat (5) @(posedge sys_clk);
        #1 resetn = 1;
        for (int i = 0; i < 24; i++) begin
            user_access_enable_bit = i[3];
            sys_op(i[0], i[2:1], i[4]);
        end
        for (int i = 0; i < 12; i++) begin
            dbg_op(i < 4 ? 12'hE20 + i[1] * 4 : 12'($urandom), i[0]);
        end
        dbg_op(12'hE20, 1'b0);
        final_report;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            final_report;
        end
    end
endmodule : pmceid_bank_tb
bind pmceid_bank pmceid_bank_props i_props(.sys_clk(sys_clk),
    .resetn(resetn), .user_access_enable_bit(user_access_enable_bit),
    .sys_req(sys_req), .sys_rsp(sys_rsp), .dbg_req(dbg_req),
    .dbg_rsp(dbg_rsp));
